// ==== hw/fsc_top.sv ====
// fuse store, fuse latching, signature space and programming command port
//
// Contract
// - three fuse bytes, programmed reads 0
// - extended byte brown-out level, reserved bits default 1
// - high bit7 debug off, bit6 scan on
// - high bit5 serial prog on, bit4 watchdog off
// - high bit3 keeps eeprom, default unprogrammed
// - high bits2..1 boot size programmed, bit0 vector
// - low bit7 divide by eight, bit6 clock out
// - low startup 10, clock source 0010
// - serial prog fuse hidden in serial mode
// - chip erase leaves fuses unchanged
// - first lock bit programmed blocks fuse writes
// - fuses latched at programming mode entry
// - eeprom keep fuse acts immediately
// - fuses latched at power-up in normal mode
// - signature readable even when locked
// - signature bytes at addresses zero to two
// - calibration byte copied to trim at reset
// - action select decides load strobe action
// - write or read strobe runs loaded command
// - action codes address, data, command, idle
// - commands chip erase, read signature, write fuse, read fuse
`timescale 1ns/1ps
module fsc_top import fsc_pkg::*; #(
	parameter fsc_byte_t SIG_VALUE0 = 8'h5a, // arbitrary value
	parameter fsc_byte_t SIG_VALUE1 = 8'h3c, // arbitrary value
	parameter fsc_byte_t SIG_VALUE2 = 8'h42, // arbitrary value
	parameter fsc_byte_t CAL_VALUE  = 8'h80
) (
	// clock and reset
	input  wire logic      core_clk,
	input  wire logic      rst_b,
	// programming pins
	input  wire fsc_pins_s prog_pins,
	input  wire fsc_byte_t data_in,
	output fsc_byte_t      data_out,
	output logic           data_oe,
	output logic           rdy_bsy,
	// lock byte from the lock logic, same clock
	input  wire fsc_byte_t lock_byte,
	// configuration towards the rest of the chip
	output fsc_fuse_s      fuse_cfg,
	output logic           keep_eeprom_on_erase,
	output fsc_byte_t      rc_trim_register,
	output logic           chip_erase_req
);
	fsc_pins_s   pins_s;
	fsc_byte_t   data_s;
	logic        strobe_d_reg;
	logic        write_d_reg;
	logic        prog_d_reg;
	logic        load_rise;
	logic        write_fall;
	logic        read_en;
	fsc_action_e action;
	fsc_sel_e    sel;
	fsc_byte_t   addr_reg;
	fsc_byte_t   cmd_reg;
	fsc_byte_t   data_reg;
	fsc_fuse_s   fuse_reg;
	fsc_fuse_s   latch_reg;
	logic        powerup_done_reg;
	fsc_state_e  state_reg;
	logic [BUSY_CNT_W-1:0] busy_cnt_reg;
	logic        write_go;
	logic        erase_go;
	logic        fuse_locked;
	fsc_byte_t   read_next;
	fsc_byte_t   high_next;

	// pins are slow against the core clock: a 250 ns pulse spans many
	// cycles, so two flops of delay lose no strobe
	fsc_sync #(.WIDTH($bits(fsc_pins_s))) u_pin_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.async_in (prog_pins),
		.sync_out (pins_s)
	);

	fsc_sync #(.WIDTH($bits(fsc_byte_t))) u_data_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.async_in (data_in),
		.sync_out (data_s)
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			strobe_d_reg <= 1'b0;
			write_d_reg  <= 1'b0;
			prog_d_reg   <= 1'b0;
		end else begin
			strobe_d_reg <= pins_s.load_strobe_pin;
			write_d_reg  <= pins_s.write_strobe_b;
			prog_d_reg   <= pins_s.prog_mode;
		end
	end

	assign load_rise  = pins_s.prog_mode & pins_s.load_strobe_pin
		& ~strobe_d_reg;
	assign write_fall = pins_s.prog_mode & ~pins_s.write_strobe_b
		& write_d_reg;
	assign read_en    = pins_s.prog_mode & ~pins_s.out_enable_b;
	assign action     = fsc_action_e'({pins_s.load_action_sel_hi,
		pins_s.load_action_sel_lo});
	assign sel        = fsc_sel_e'({pins_s.byte_sel_2,
		pins_s.byte_sel_hi});
	assign fuse_locked = ~lock_byte[LOCK_FIRST_BIT];

	// load strobe: address, data or command by the action pins
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_reg <= '0;
			cmd_reg  <= '0;
			data_reg <= ALL_ONES;
		end else if (load_rise) begin
			case (action)
				ACT_ADDR: begin
					if (!pins_s.byte_sel_hi) begin
						addr_reg <= data_s;
					end
				end
				ACT_DATA: data_reg <= data_s;
				ACT_CMD:  cmd_reg  <= data_s;
				default: ;
			endcase
		end
	end

	// write strobe runs the last loaded command
	assign write_go = write_fall && state_reg == ST_READY
		&& cmd_reg == CMD_WRITE_FUSE && !fuse_locked;
	assign erase_go = write_fall && state_reg == ST_READY
		&& cmd_reg == CMD_CHIP_ERASE;

	// the serial prog fuse cannot be altered from serial mode
	always_comb begin
		high_next = data_reg;
		if (pins_s.serial_mode) begin
			high_next[HIGH_SERIAL_PROG] =
				fuse_reg.high[HIGH_SERIAL_PROG];
		end
	end

	// fuse store; reset stands in for the nonvolatile defaults
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fuse_reg.ext  <= EXT_DEFAULT;
			fuse_reg.high <= HIGH_DEFAULT;
			fuse_reg.low  <= LOW_DEFAULT;
		end else if (write_go) begin
			case (sel)
				SEL_LOW:  fuse_reg.low  <= data_reg;
				SEL_HIGH: fuse_reg.high <= high_next;
				SEL_EXT:  fuse_reg.ext  <= data_reg;
				default: ;
			endcase
		end
	end

	// erase only flags the memory logic; fuses are untouched
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			chip_erase_req <= 1'b0;
		end else begin
			chip_erase_req <= erase_go;
		end
	end

	// busy window after a chip erase or an unlocked fuse write
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg    <= ST_READY;
			busy_cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_READY: begin
					if (write_go || erase_go) begin
						state_reg    <= ST_BUSY;
						busy_cnt_reg <=
							BUSY_CNT_W'(WRITE_BUSY_CYC - 1);
					end
				end
				ST_BUSY: begin
					if (busy_cnt_reg == '0) begin
						state_reg <= ST_READY;
					end else begin
						busy_cnt_reg <= busy_cnt_reg - 1'b1;
					end
				end
				default: state_reg <= ST_READY;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdy_bsy <= 1'b1;
		end else begin
			rdy_bsy <= (state_reg == ST_READY) && !write_go
				&& !erase_go;
		end
	end

	// latched copy: at power-up in normal mode, at entry to and exit
	// from programming mode; held while in programming mode
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_reg        <= {EXT_DEFAULT, HIGH_DEFAULT, LOW_DEFAULT};
			powerup_done_reg <= 1'b0;
		end else begin
			if (!powerup_done_reg && !pins_s.prog_mode) begin
				latch_reg        <= fuse_reg;
				powerup_done_reg <= 1'b1;
			end else if (pins_s.prog_mode != prog_d_reg) begin
				latch_reg        <= fuse_reg;
				powerup_done_reg <= 1'b1;
			end
		end
	end

	assign fuse_cfg = latch_reg;
	// the eeprom keep fuse bypasses the latch
	assign keep_eeprom_on_erase = fuse_reg.high[HIGH_KEEP_EEPROM];

	// trim takes the calibration byte while reset is held
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rc_trim_register <= CAL_VALUE;
		end else begin
			rc_trim_register <= rc_trim_register;
		end
	end

	// read data; signature reads ignore the lock byte
	always_comb begin
		read_next = ALL_ONES;
		if (cmd_reg == CMD_READ_SIG) begin
			if (addr_reg == SIG_ADDR0 && pins_s.byte_sel_hi) begin
				read_next = CAL_VALUE;
			end else if (addr_reg == SIG_ADDR0) begin
				read_next = SIG_VALUE0;
			end else if (addr_reg == SIG_ADDR1) begin
				read_next = SIG_VALUE1;
			end else if (addr_reg == SIG_ADDR2) begin
				read_next = SIG_VALUE2;
			end
		end else if (cmd_reg == CMD_READ_FUSE) begin
			case (sel)
				SEL_LOW:  read_next = fuse_reg.low;
				SEL_HIGH: begin
					read_next = fuse_reg.high;
					if (pins_s.serial_mode) begin
						read_next[HIGH_SERIAL_PROG] = 1'b1;
					end
				end
				SEL_EXT:  read_next = fuse_reg.ext;
				default:  read_next = lock_byte;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_out <= ALL_ONES;
			data_oe  <= 1'b0;
		end else begin
			data_out <= read_next;
			data_oe  <= read_en;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_lock_blocks_write: assert property (
		write_fall && fuse_locked |=> $stable(fuse_reg))
		else $error("fuse changed while locked");

	a_erase_keeps_fuses: assert property (
		erase_go |=> $stable(fuse_reg) ##1 $stable(fuse_reg))
		else $error("chip erase altered fuses");

	a_entry_latch_copy: assert property (
		pins_s.prog_mode && !prog_d_reg && powerup_done_reg
		|=> latch_reg == $past(fuse_reg))
		else $error("fuses not latched on entry");

	a_prog_latch_hold: assert property (
		pins_s.prog_mode && prog_d_reg ##1 pins_s.prog_mode
		|-> $stable(latch_reg))
		else $error("latched fuses moved in programming mode");

	a_keep_eeprom_live: assert property (
		write_go && sel == SEL_HIGH
		|=> keep_eeprom_on_erase == $past(data_reg[HIGH_KEEP_EEPROM]))
		else $error("eeprom keep fuse not immediate");

	a_write_goes_busy: assert property (
		write_go |=> !rdy_bsy ##1 state_reg == ST_BUSY)
		else $error("fuse write did not raise busy");

	a_sig_byte_one: assert property (
		cmd_reg == CMD_READ_SIG && addr_reg == SIG_ADDR1
		&& !pins_s.byte_sel_hi |=> data_out == SIG_VALUE1)
		else $error("wrong signature byte one");

	a_serial_hides_bit: assert property (
		cmd_reg == CMD_READ_FUSE && sel == SEL_HIGH
		&& pins_s.serial_mode |=> data_out[HIGH_SERIAL_PROG])
		else $error("serial prog fuse visible in serial mode");

	a_cmd_load_taken: assert property (
		load_rise && action == ACT_CMD |=> cmd_reg == $past(data_s))
		else $error("command byte not loaded");

	a_powerup_latch: assert property (
		!powerup_done_reg && !pins_s.prog_mode
		|=> powerup_done_reg && latch_reg == $past(fuse_reg))
		else $error("fuses not latched at power-up");
endmodule

// ==== pkg/fsc_pkg.sv ====
// constants and carrier types for the fuse and signature block
package fsc_pkg;
	typedef logic [7:0] fsc_byte_t;

	// three fuse bytes, 0 = programmed
	typedef struct packed {
		fsc_byte_t ext;
		fsc_byte_t high;
		fsc_byte_t low;
	} fsc_fuse_s;

	// parallel programming pins as they arrive from outside
	typedef struct packed {
		logic prog_mode;
		logic serial_mode;
		logic load_strobe_pin;
		logic load_action_sel_hi;
		logic load_action_sel_lo;
		logic byte_sel_hi;
		logic byte_sel_2;
		logic write_strobe_b;
		logic out_enable_b;
	} fsc_pins_s;

	localparam fsc_byte_t EXT_DEFAULT  = 8'hff;
	localparam fsc_byte_t HIGH_DEFAULT = 8'h99;
	localparam fsc_byte_t LOW_DEFAULT  = 8'h62;
	localparam fsc_byte_t ALL_ONES     = 8'hff;

	// field positions
	localparam int EXT_BROWNOUT_MSB = 3;
	localparam int EXT_BROWNOUT_LSB = 1;
	localparam int EXT_FACTORY_TEST = 0;
	localparam int HIGH_DEBUG       = 7;
	localparam int HIGH_SCAN        = 6;
	localparam int HIGH_SERIAL_PROG = 5;
	localparam int HIGH_WATCHDOG    = 4;
	localparam int HIGH_KEEP_EEPROM = 3;
	localparam int HIGH_BOOT_HI     = 2;
	localparam int HIGH_BOOT_LO     = 1;
	localparam int HIGH_RESET_VEC   = 0;
	localparam int LOW_PREDIV8      = 7;
	localparam int LOW_CLK_OUT      = 6;
	localparam int LOW_STARTUP_MSB  = 5;
	localparam int LOW_STARTUP_LSB  = 4;
	localparam int LOW_CLK_SRC_MSB  = 3;
	localparam int LOW_CLK_SRC_LSB  = 0;
	localparam int LOCK_FIRST_BIT   = 0;

	localparam fsc_byte_t CMD_CHIP_ERASE = 8'h80;
	localparam fsc_byte_t CMD_WRITE_FUSE = 8'h40;
	localparam fsc_byte_t CMD_READ_SIG   = 8'h08;
	localparam fsc_byte_t CMD_READ_FUSE  = 8'h04;

	localparam fsc_byte_t SIG_ADDR0 = 8'h00;
	localparam fsc_byte_t SIG_ADDR1 = 8'h01;
	localparam fsc_byte_t SIG_ADDR2 = 8'h02;

	typedef enum logic [1:0] {
		ACT_ADDR = 2'b00,
		ACT_DATA = 2'b01,
		ACT_CMD  = 2'b10,
		ACT_IDLE = 2'b11
	} fsc_action_e;

	typedef enum logic [1:0] {
		SEL_LOW  = 2'b00,
		SEL_HIGH = 2'b01,
		SEL_EXT  = 2'b10,
		SEL_LOCK = 2'b11
	} fsc_sel_e;

	typedef enum logic {
		ST_READY = 1'b0,
		ST_BUSY  = 1'b1
	} fsc_state_e;

	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_BUSY_NS = 2000;
	localparam int WRITE_BUSY_CYC =
		(WRITE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CNT_W = $clog2(WRITE_BUSY_CYC + 1);
endpackage

// ==== hw/fsc_sync.sv ====
// two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
module fsc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	// asynchronous in, synchronised out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ==== test/fsc_prog_model.sv ====
// parallel programmer model driving the device programming pins
`timescale 1ns/1ps
module fsc_prog_model import fsc_pkg::*; #(
	parameter int PULSE_CYC = 26
) (
	// clock
	input  wire logic      core_clk,
	// device answers
	input  wire fsc_byte_t data_out,
	input  wire logic      data_oe,
	input  wire logic      rdy_bsy,
	// pins towards the device
	output fsc_pins_s      prog_pins,
	output fsc_byte_t      data_in
);
	initial begin
		prog_pins = 9'h0;
		prog_pins.load_action_sel_hi = 1'b1;
		prog_pins.load_action_sel_lo = 1'b1;
		prog_pins.write_strobe_b = 1'b1;
		prog_pins.out_enable_b = 1'b1;
		data_in = 8'hff;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic set_mode(input logic prog, input logic ser);
		tick(1);
		prog_pins.prog_mode = prog;
		prog_pins.serial_mode = ser;
		tick(PULSE_CYC);
	endtask
	// every level is held a full pulse width so the synchronisers see it
	task automatic load(input fsc_action_e act, input logic hi,
		input fsc_byte_t val);
		tick(1);
		{prog_pins.load_action_sel_hi,
			prog_pins.load_action_sel_lo} = act;
		prog_pins.byte_sel_hi = hi;
		data_in = val;
		tick(PULSE_CYC);
		prog_pins.load_strobe_pin = 1'b1;
		tick(PULSE_CYC);
		prog_pins.load_strobe_pin = 1'b0;
		tick(PULSE_CYC);
		// released bus must not keep looking like valid data
		data_in = ~val;
	endtask
	task automatic write(input logic [1:0] sel, output logic busy_seen);
		int n;
		tick(1);
		{prog_pins.byte_sel_2, prog_pins.byte_sel_hi} = sel;
		prog_pins.write_strobe_b = 1'b0;
		busy_seen = 1'b0;
		for (n = 0; n < PULSE_CYC; n++) begin
			tick(1);
			if (rdy_bsy === 1'b0)
				busy_seen = 1'b1;
		end
		prog_pins.write_strobe_b = 1'b1;
		for (n = 0; n < 400 && rdy_bsy !== 1'b1; n++)
			tick(1);
	endtask
	task automatic read(input logic [1:0] sel, output fsc_byte_t val,
		output logic oe);
		tick(1);
		{prog_pins.byte_sel_2, prog_pins.byte_sel_hi} = sel;
		prog_pins.out_enable_b = 1'b0;
		tick(PULSE_CYC);
		val = data_out;
		oe = data_oe;
		prog_pins.out_enable_b = 1'b1;
		tick(PULSE_CYC);
	endtask
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the fuse and signature block
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) begin \
			failures++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module tb_top import fsc_pkg::*; ();
	localparam fsc_byte_t SIG0 = 8'ha7; // arbitrary value
	localparam fsc_byte_t SIG1 = 8'h3d; // arbitrary value
	localparam fsc_byte_t SIG2 = 8'h6e; // arbitrary value
	localparam fsc_byte_t CAL  = 8'hc5;
	logic      core_clk;
	logic      rst_b;
	fsc_pins_s prog_pins;
	fsc_byte_t data_in;
	fsc_byte_t data_out;
	fsc_byte_t lock_byte;
	fsc_byte_t rc_trim_register;
	fsc_byte_t rd;
	fsc_fuse_s fuse_cfg;
	logic      data_oe;
	logic      rdy_bsy;
	logic      keep_eeprom_on_erase;
	logic      chip_erase_req;
	logic      oe;
	logic      bsy;
	int        failures;
	int        checks_done;
	int        cycles;
	int        erase_seen;
	fsc_top #(.SIG_VALUE0(SIG0), .SIG_VALUE1(SIG1), .SIG_VALUE2(SIG2),
		.CAL_VALUE(CAL)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
		.prog_pins(prog_pins), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .rdy_bsy(rdy_bsy), .lock_byte(lock_byte),
		.fuse_cfg(fuse_cfg), .keep_eeprom_on_erase(keep_eeprom_on_erase),
		.rc_trim_register(rc_trim_register),
		.chip_erase_req(chip_erase_req));
	fsc_prog_model u_prog (.core_clk(core_clk), .data_out(data_out),
		.data_oe(data_oe), .rdy_bsy(rdy_bsy), .prog_pins(prog_pins),
		.data_in(data_in));
	always #5 core_clk = ~core_clk;
	// sized well above the few thousand cycles the sequence needs
	always @(posedge core_clk) begin
		cycles++;
		if (chip_erase_req === 1'b1)
			erase_seen++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end
	task automatic final_report;
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rd_chk(input logic [1:0] sel, input fsc_byte_t exp);
		u_prog.read(sel, rd, oe);
		`CHK(rd, exp)
		`CHK(oe, 1'b1)
		// the bus must be let go once the read enable is high again
		`CHK(data_oe, 1'b0)
	endtask
	task automatic wr_fuse(input logic [1:0] sel, input fsc_byte_t val,
		input logic exp_busy);
		u_prog.load(ACT_CMD, 1'b0, CMD_WRITE_FUSE);
		u_prog.load(ACT_DATA, 1'b0, val);
		u_prog.write(sel, bsy);
		`CHK(bsy, exp_busy)
	endtask
	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		lock_byte = 8'hff;
		failures = 0;
		checks_done = 0;
		cycles = 0;
		erase_seen = 0;
		repeat (5) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		u_prog.tick(4);
		`CHK(fuse_cfg.ext, 8'hff)
		`CHK(fuse_cfg.high, 8'h99)
		`CHK(fuse_cfg.low, 8'h62)
		`CHK(keep_eeprom_on_erase, 1'b1)
		`CHK(rc_trim_register, CAL)
		`CHK(rdy_bsy, 1'b1)
		u_prog.set_mode(1'b1, 1'b0);
		u_prog.load(ACT_CMD, 1'b0, CMD_READ_FUSE);
		rd_chk(2'b00, 8'h62);
		rd_chk(2'b01, 8'h99);
		rd_chk(2'b10, 8'hff);
		// an idle load must leave the command untouched
		u_prog.load(ACT_IDLE, 1'b0, CMD_WRITE_FUSE);
		rd_chk(2'b00, 8'h62);
		u_prog.load(ACT_CMD, 1'b0, CMD_READ_SIG);
		for (int i = 0; i < 3; i++) begin
			u_prog.load(ACT_ADDR, 1'b0, 8'(i));
			rd_chk(2'b00, i == 0 ? SIG0 : i == 1 ? SIG1 : SIG2);
		end
		u_prog.load(ACT_ADDR, 1'b0, SIG_ADDR0);
		rd_chk(2'b01, CAL);
		wr_fuse(2'b00, 8'h5f, 1'b1);
		wr_fuse(2'b01, 8'h91, 1'b1);
		// extended byte: brown-out level bits programmed
		wr_fuse(2'b10, 8'hf1, 1'b1);
		`CHK(keep_eeprom_on_erase, 1'b0)
		`CHK(fuse_cfg, 24'hff9962)
		u_prog.load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
		u_prog.write(2'b00, bsy);
		`CHK(bsy, 1'b1)
		`CHK(erase_seen, 1)
		u_prog.load(ACT_CMD, 1'b0, CMD_READ_FUSE);
		rd_chk(2'b00, 8'h5f);
		rd_chk(2'b01, 8'h91);
		rd_chk(2'b10, 8'hf1);
		u_prog.set_mode(1'b0, 1'b0);
		`CHK(fuse_cfg, 24'hf1915f)
		lock_byte = 8'hfe;
		u_prog.set_mode(1'b1, 1'b0);
		wr_fuse(2'b00, 8'h00, 1'b0);
		u_prog.load(ACT_CMD, 1'b0, CMD_READ_FUSE);
		rd_chk(2'b00, 8'h5f);
		rd_chk(2'b11, 8'hfe);
		u_prog.load(ACT_CMD, 1'b0, CMD_READ_SIG);
		u_prog.load(ACT_ADDR, 1'b0, SIG_ADDR1);
		rd_chk(2'b00, SIG1);
		lock_byte = 8'hff;
		u_prog.set_mode(1'b1, 1'b1);
		u_prog.load(ACT_CMD, 1'b0, CMD_READ_FUSE);
		rd_chk(2'b01, 8'hb1);
		wr_fuse(2'b01, 8'hb9, 1'b1);
		`CHK(keep_eeprom_on_erase, 1'b1)
		u_prog.set_mode(1'b1, 1'b0);
		u_prog.load(ACT_CMD, 1'b0, CMD_READ_FUSE);
		rd_chk(2'b01, 8'h99);
		final_report();
	end
endmodule
